// ==== bench/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import upio_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, bank_select_enable = 1'b0, bank_addr_bit = 1'b0;
  upio_sfr_s sfr = '0;
  upio_xd_s xd = '0;
  logic [7:0] sfr_rdata, xd_rdata, port_a_i, port_b_i, port_c_i, port_d_i;
  logic [7:0] chip_select_n = 8'hfe, ext_a = 8'h3c, ext_b = 8'h00, ext_c = 8'h55, ext_d = 8'h00;
  logic [1:0] wake_input_pair = 2'b01;
  upio_pin_s port_a, port_b, port_c, port_d;
  logic timer0_count_input, timer1_count_input, timer2_count_input, timer2_external_trigger;
  int err_total = 0, cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  upio_ports dut_u (.ref_clk, .sys_rst, .sfr, .sfr_rdata, .xd, .xd_rdata, .bank_select_enable,
    .bank_addr_bit, .chip_select_n, .port_a_i, .port_b_i, .port_c_i, .port_d_i,
    .wake_input_pair, .port_a, .port_b, .port_c, .port_d, .timer0_count_input,
    .timer1_count_input, .timer2_count_input, .timer2_external_trigger);
  upio_pads pa_u (.pad(port_a), .ext(ext_a), .lvl(port_a_i));
  upio_pads pb_u (.pad(port_b), .ext(ext_b), .lvl(port_b_i));
  upio_pads pc_u (.pad(port_c), .ext(ext_c), .lvl(port_c_i));
  upio_pads pd_u (.pad(port_d), .ext(ext_d), .lvl(port_d_i));
  wire [7:0] tmr = {4'h0, timer2_count_input, timer2_external_trigger, timer1_count_input,
                    timer0_count_input};
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes drop for a cycle between requests so no signal changes twice in one step
  task automatic sfr_op(input logic w, input logic m, input logic [7:0] a, input logic [7:0] d);
    sfr = '{wr: w, rd: !w, rmw: m, addr: a, wdata: d};
    tick(1);
    if (!w) chk(sfr_rdata, d);
    sfr = '0;
    tick(1);
  endtask
  task automatic xd_op(input logic w, input logic [15:0] a, input logic [7:0] d);
    xd = '{wr: w, rd: !w, addr: a, wdata: d};
    tick(1);
    if (!w) chk(xd_rdata, d);
    xd = '0;
    tick(1);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    close_out;
  end
  initial begin
    tick(2);
    sys_rst = 1'b0;
    sfr_op(1'b0, 1'b0, SFR_PORT_A_DATA, 8'hff);
    sfr_op(1'b0, 1'b1, SFR_PORT_A_DATA, 8'h00);
    sfr_op(1'b0, 1'b0, SFR_PORT_A_DIR, 8'hff);
    xd_op(1'b0, XD_PORT_C_DIR, 8'hff);
    xd_op(1'b0, XD_PORT_C_DATA, 8'hff);
    chk(tmr, 8'h0f);
    chk(port_d.oe, 8'hff);
    chk(port_d.o, 8'hfe);
    sfr_op(1'b0, 1'b0, 8'h80, 8'h00);
    xd_op(1'b0, 16'h0100, 8'h00);
    xd_op(1'b0, XD_WAKE_PAIR, 8'h40);
    $display("test 1 done");
    sfr_op(1'b1, 1'b0, SFR_PORT_A_DATA, 8'ha5);
    sfr_op(1'b1, 1'b0, SFR_PORT_A_DIR, 8'h0f);
    tick(5);
    sfr_op(1'b0, 1'b0, SFR_PORT_A_DATA, 8'hac);
    sfr_op(1'b0, 1'b1, SFR_PORT_A_DATA, 8'ha5);
    chk(port_a.oe, 8'hf0);
    chk(port_a.o & port_a.oe, 8'ha0);
    chk(tmr, 8'h0c);
    sfr_op(1'b1, 1'b0, SFR_PORT_A_DATA, 8'h5a);
    chk(port_a.o & port_a.oe, 8'h50);
    $display("test 2 done");
    sfr_op(1'b1, 1'b1, SFR_PORT_B_DATA, 8'h5a);
    tick(5);
    sfr_op(1'b0, 1'b0, SFR_PORT_B_DATA, 8'hff);
    sfr_op(1'b1, 1'b0, SFR_PORT_B_DIR, 8'h00);
    tick(5);
    sfr_op(1'b0, 1'b0, SFR_PORT_B_DATA, 8'h5a);
    chk(port_b.oe, 8'hff);
    $display("test 3 done");
    xd_op(1'b1, XD_PORT_C_DATA, 8'h43);
    xd_op(1'b1, XD_PORT_C_DIR, 8'hf0);
    tick(5);
    xd_op(1'b0, XD_PORT_C_DATA, 8'h53);
    xd_op(1'b0, XD_PORT_C_DIR, 8'hf0);
    bank_select_enable = 1'b1;
    bank_addr_bit = 1'b1;
    tick(3);
    chk(port_c.oe, 8'h8f);
    chk(port_c.o & port_c.oe, 8'h83);
    $display("test 4 done");
    xd_op(1'b1, XD_PORT_D_CSEN, 8'hf0);
    xd_op(1'b1, XD_PORT_D_DATA, 8'h0a);
    xd_op(1'b1, XD_PORT_D_DIR, 8'h00);
    tick(5);
    chk(port_d.oe, 8'hff);
    chk(port_d.o, 8'hfa);
    xd_op(1'b0, XD_PORT_D_DATA, 8'hfa);
    xd_op(1'b0, XD_PORT_D_CSEN, 8'hf0);
    $display("test 5 done");
    close_out;
  end
endmodule

// ==== bench/upio_pads.sv ====
// outside world: drives a pin only where the device has released it
module upio_pads
  import upio_pkg::*;
(
  input upio_pin_s        pad,
  input wire logic  [7:0] ext,
  output logic      [7:0] lvl
);
  assign lvl = (pad.o & pad.oe) | (ext & ~pad.oe);
endmodule

// ==== bench/upio_ports_asserts.sv ====
module upio_ports_asserts
  import upio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input upio_sfr_s sfr,
  input logic [7:0] sfr_rdata,
  input upio_xd_s  xd,
  input logic [7:0] xd_rdata,
  input wire logic bank_select_enable,
  input wire logic bank_addr_bit,
  input upio_pin_s port_a,
  input upio_pin_s port_b,
  input upio_pin_s port_c,
  input logic      timer0_count_input,
  input logic      timer1_count_input,
  input logic      timer2_count_input,
  input logic      timer2_external_trigger
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic a_dir_seen;
  wire  tmr_all = timer0_count_input & timer1_count_input & timer2_count_input
                & timer2_external_trigger;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) a_dir_seen <= 1'b0;
    else if (sfr.wr && sfr.addr == SFR_PORT_A_DIR) a_dir_seen <= 1'b1;
  end
  pads_float_a: assert property (
    $fell(sys_rst) |-> (port_a.oe | port_b.oe | port_c.oe) == 8'h00)
    else $error("pads driven after reset");
  rdata_clear_a: assert property (
    $fell(sys_rst) |-> sfr_rdata == 8'h00 && xd_rdata == 8'h00)
    else $error("read data not clear after reset");
  forced_timer_a: assert property (!a_dir_seen |-> tmr_all)
    else $error("timer inputs not forced high");
  dir_drive_a: assert property (
    sfr.wr && sfr.addr == SFR_PORT_A_DIR |-> ##2 port_a.oe == ~$past(sfr.wdata, 2))
    else $error("port a enables do not follow direction");
  data_drive_a: assert property (
    sfr.wr && sfr.addr == SFR_PORT_A_DATA
      |-> ##2 (port_a.o & port_a.oe) == ($past(sfr.wdata, 2) & port_a.oe))
    else $error("port a drive does not follow data");
  bank_pin_a: assert property (
    $past(bank_select_enable) && !$past(sys_rst)
      |-> port_c.oe[7] && port_c.o[7] == $past(bank_addr_bit))
    else $error("bank address pin not driven");
  unmapped_read_a: assert property (
    xd.rd && xd.addr > XD_WAKE_PAIR |=> xd_rdata == 8'h00)
    else $error("unmapped read not zero");
  wake_read_a: assert property (
    xd.rd && xd.addr == XD_WAKE_PAIR |=> xd_rdata[4:0] == 5'h00)
    else $error("wake register spare bits set");
endmodule
bind upio_ports upio_ports_asserts chk_u (.ref_clk, .sys_rst, .sfr, .sfr_rdata, .xd, .xd_rdata,
  .bank_select_enable, .bank_addr_bit, .port_a, .port_b, .port_c, .timer0_count_input,
  .timer1_count_input, .timer2_count_input, .timer2_external_trigger);

// ==== pkg/upio_pkg.sv ====
package upio_pkg;
  // internal special function register bus offsets
  localparam logic [7:0] SFR_PORT_A_DATA = 8'h90;
  localparam logic [7:0] SFR_PORT_A_DIR  = 8'h91;
  localparam logic [7:0] SFR_PORT_B_DATA = 8'hd8;
  localparam logic [7:0] SFR_PORT_B_DIR  = 8'hd9;
  // external data space offsets
  localparam logic [15:0] XD_PORT_C_DATA = 16'h0000;
  localparam logic [15:0] XD_PORT_C_DIR  = 16'h0001;
  localparam logic [15:0] XD_PORT_D_DATA = 16'h0003;
  localparam logic [15:0] XD_PORT_D_DIR  = 16'h0004;
  localparam logic [15:0] XD_PORT_D_CSEN = 16'h0005;
  localparam logic [15:0] XD_WAKE_PAIR   = 16'h0006;
  // reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET  = 8'hff;
  localparam logic [7:0] CSEN_RESET = 8'hff;
  localparam logic [7:0] INPUT_FORCED = 8'hff;
  // field positions
  localparam int BANK_PIN      = 7;
  localparam int WAKE_BIT0_POS = 6;
  localparam int WAKE_BIT1_POS = 5;
  localparam int TMR0_POS      = 0;
  localparam int TMR1_POS      = 1;
  localparam int TMR2_TRIG_POS = 2;
  localparam int TMR2_POS      = 3;
  localparam int NUM_PORTS     = 4;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } upio_sfr_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } upio_xd_s;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } upio_pin_s;
endpackage

// ==== src/upio_port_bit.sv ====
// one 8-bit port: data latch, direction latch, reset hold, pad sync
module upio_port_bit
  import upio_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       data_we,
  input  wire logic       dir_we,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] pin_i,
  input  wire logic [7:0] force_out,
  input  wire logic [7:0] force_val,
  output logic      [7:0] data_q,
  output logic      [7:0] dir_q,
  output logic      [7:0] pin_level,
  output upio_pin_s       pad
);
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic       held;
  wire  [7:0] drive_en;
  wire  [7:0] drive_val;
  wire  [7:0] next_oe;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_q <= DATA_RESET;
      dir_q  <= DIR_RESET;
      held   <= 1'b1;
    end else begin
      if (data_we) data_q <= wdata;
      if (dir_we) begin
        dir_q <= wdata;
        held  <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    sync1 <= pin_i;
    sync2 <= sync1;
  end

  // direction 0 drives, 1 listens; forced bits override both
  assign drive_en  = force_out | (held ? 8'h00 : ~dir_q);
  assign drive_val = (force_out & force_val) | (~force_out & data_q);
  assign next_oe   = drive_en;
  assign pin_level = held ? INPUT_FORCED : sync2;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pad.o  <= 8'h00;
      pad.oe <= 8'h00;
    end else begin
      pad.o  <= drive_val;
      pad.oe <= next_oe;
    end
  end
endmodule

// ==== src/upio_ports.sv ====
module upio_ports
  import upio_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  upio_sfr_s       sfr,
  output logic      [7:0] sfr_rdata,
  input  upio_xd_s        xd,
  output logic      [7:0] xd_rdata,
  input  wire logic       bank_select_enable,
  input  wire logic       bank_addr_bit,
  input  wire logic [7:0] chip_select_n,
  input  wire logic [7:0] port_a_i,
  input  wire logic [7:0] port_b_i,
  input  wire logic [7:0] port_c_i,
  input  wire logic [7:0] port_d_i,
  input  wire logic [1:0] wake_input_pair,
  output upio_pin_s       port_a,
  output upio_pin_s       port_b,
  output upio_pin_s       port_c,
  output upio_pin_s       port_d,
  output logic            timer0_count_input,
  output logic            timer1_count_input,
  output logic            timer2_count_input,
  output logic            timer2_external_trigger
);
  logic [7:0] csen;
  logic [1:0] wake_s1;
  logic [1:0] wake_s2;
  logic [7:0] data_q  [NUM_PORTS];
  logic [7:0] dir_q   [NUM_PORTS];
  logic [7:0] level   [NUM_PORTS];
  logic [7:0] pin_in  [NUM_PORTS];
  upio_pin_s  pad     [NUM_PORTS];
  wire  [NUM_PORTS-1:0] data_we;
  wire  [NUM_PORTS-1:0] dir_we;
  wire  [7:0] force_out [NUM_PORTS];
  wire  [7:0] force_val [NUM_PORTS];
  wire        csen_we;
  wire  [7:0] next_sfr_rdata;
  wire  [7:0] next_xd_rdata;
  wire  [7:0] port_wdata [NUM_PORTS];
  wire        sel_a_data;
  wire        sel_a_dir;
  wire        sel_b_data;
  wire        sel_b_dir;
  wire        sel_c_data;
  wire        sel_c_dir;
  wire        sel_d_data;
  wire        sel_d_dir;
  wire        sel_csen;
  wire        sel_wake;
  wire  [7:0] a_data_view;
  wire  [7:0] b_data_view;
  wire  [7:0] wake_view;
  logic [3:0] timer_tap;
  wire  [3:0] next_timer_tap;

  function automatic logic sfr_hit(input upio_sfr_s b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  function automatic logic xd_hit(input upio_xd_s b, input logic [15:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // byte writes; the core's bit ops arrive here as read-modify-write bytes
  assign data_we[0] = sfr_hit(sfr, SFR_PORT_A_DATA);
  assign dir_we[0]  = sfr_hit(sfr, SFR_PORT_A_DIR);
  assign data_we[1] = sfr_hit(sfr, SFR_PORT_B_DATA);
  assign dir_we[1]  = sfr_hit(sfr, SFR_PORT_B_DIR);
  assign data_we[2] = xd_hit(xd, XD_PORT_C_DATA);
  assign dir_we[2]  = xd_hit(xd, XD_PORT_C_DIR);
  assign data_we[3] = xd_hit(xd, XD_PORT_D_DATA);
  assign dir_we[3]  = xd_hit(xd, XD_PORT_D_DIR);
  assign csen_we    = xd_hit(xd, XD_PORT_D_CSEN);

  assign pin_in[0] = port_a_i;
  assign pin_in[1] = port_b_i;
  assign pin_in[2] = port_c_i;
  assign pin_in[3] = port_d_i;

  assign force_out[0] = 8'h00;
  assign force_val[0] = 8'h00;
  assign force_out[1] = 8'h00;
  assign force_val[1] = 8'h00;
  // bank bit takes over pin 7 and ignores the data latch there
  assign force_out[2] = 8'(bank_select_enable) << BANK_PIN;
  assign force_val[2] = 8'(bank_addr_bit) << BANK_PIN;
  assign force_out[3] = csen;
  assign force_val[3] = chip_select_n;

  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      assign port_wdata[p] = (p < 2) ? sfr.wdata : xd.wdata;
      upio_port_bit u_port (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .data_we   (data_we[p]),
        .dir_we    (dir_we[p]),
        .wdata     (port_wdata[p]),
        .pin_i     (pin_in[p]),
        .force_out (force_out[p]),
        .force_val (force_val[p]),
        .data_q    (data_q[p]),
        .dir_q     (dir_q[p]),
        .pin_level (level[p]),
        .pad       (pad[p])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (sys_rst) csen <= CSEN_RESET;
    else if (csen_we) csen <= xd.wdata;
  end

  always_ff @(posedge ref_clk) begin
    wake_s1 <= wake_input_pair;
    wake_s2 <= wake_s1;
  end

  // read-side decode; write strobes use the hit functions above
  assign sel_a_data = (sfr.addr == SFR_PORT_A_DATA);
  assign sel_a_dir  = (sfr.addr == SFR_PORT_A_DIR);
  assign sel_b_data = (sfr.addr == SFR_PORT_B_DATA);
  assign sel_b_dir  = (sfr.addr == SFR_PORT_B_DIR);
  assign sel_c_data = (xd.addr == XD_PORT_C_DATA);
  assign sel_c_dir  = (xd.addr == XD_PORT_C_DIR);
  assign sel_d_data = (xd.addr == XD_PORT_D_DATA);
  assign sel_d_dir  = (xd.addr == XD_PORT_D_DIR);
  assign sel_csen   = (xd.addr == XD_PORT_D_CSEN);
  assign sel_wake   = (xd.addr == XD_WAKE_PAIR);

  // pins are reported, latches only for the read half of read-modify-write
  assign a_data_view = sfr.rmw ? data_q[0] : level[0];
  assign b_data_view = sfr.rmw ? data_q[1] : level[1];
  // only the two live pin bits are built; the wake setup bits of that word read zero
  assign wake_view = (8'(wake_s2[0]) << WAKE_BIT0_POS)
                   | (8'(wake_s2[1]) << WAKE_BIT1_POS);

  assign next_sfr_rdata =
    sel_a_data ? a_data_view :
    sel_a_dir  ? dir_q[0] :
    sel_b_data ? b_data_view :
    sel_b_dir  ? dir_q[1] : 8'h00;

  // external reads never see the data latches, only the pins
  assign next_xd_rdata =
    sel_c_data ? level[2] :
    sel_c_dir  ? dir_q[2] :
    sel_d_data ? level[3] :
    sel_d_dir  ? dir_q[3] :
    sel_csen   ? csen :
    sel_wake   ? wake_view : 8'h00;

  // read data holds between reads so the core may take it late
  always_ff @(posedge ref_clk) begin
    if (sys_rst) sfr_rdata <= 8'h00;
    else if (sfr.rd) sfr_rdata <= next_sfr_rdata;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) xd_rdata <= 8'h00;
    else if (xd.rd) xd_rdata <= next_xd_rdata;
  end

  // timers see the port A input value, forced to one until configured
  assign next_timer_tap[0] = level[0][TMR0_POS];
  assign next_timer_tap[1] = level[0][TMR1_POS];
  assign next_timer_tap[2] = level[0][TMR2_TRIG_POS];
  assign next_timer_tap[3] = level[0][TMR2_POS];

  // a pin set to output still reaches its timer; software is told to avoid that
  always_ff @(posedge ref_clk) begin
    if (sys_rst) timer_tap <= INPUT_FORCED[3:0];
    else timer_tap <= next_timer_tap;
  end

  assign timer0_count_input      = timer_tap[0];
  assign timer1_count_input      = timer_tap[1];
  assign timer2_external_trigger = timer_tap[2];
  assign timer2_count_input      = timer_tap[3];

  assign port_a = pad[0];
  assign port_b = pad[1];
  assign port_c = pad[2];
  assign port_d = pad[3];
endmodule
